/* File: rtl/doag_pkg.sv */
/*
 Constants, types and encodings for the data operand address generator.
 Assumes one core clock domain; shared by the generator and the bench.
*/
// Contract
// - Bank registers R0-R7, WR0-WR6, DR0, DR4 follow the status-word bank select.
// - Every bank is also reachable as memory bytes 00H-1FH.
// - Legacy direct below 80H is RAM, 80H up is SFR, bytes only.
// - Extended direct8 reaches RAM as byte or word, SFR as byte only.
// - Direct16 reaches bytes or words anywhere in region 00:.
// - Byte-pointer indirect reaches 256 RAM bytes or lowest 256 external bytes.
// - Data pointer, optionally plus accumulator, addresses 64K of external memory.
// - Code move forms accumulator plus pointer or counter in region FF:.
// - Two-bit immediate means step 1, 2 or 4, increment/decrement only.
// - Extended byte ops take 8-bit immediates, word ops 16-bit.
// - Dword immediate: low word data, upper word all zeros or ones.
// - Dword move: write upper word keeping low, or low word extended.
// - 24-bit dword indirect spans 16M; register upper byte must be zero.
// - 16-bit displacement adds signed offset to word base, wraps in 00:.
// - 24-bit displacement adds signed offset to dword base, upper byte zero.
// - Legacy external accesses use region byte, reset value 01H.
// - Writing pointer dword or region SFR changes later legacy region.
// - Implemented SFRs lie only within S:080H-S:0FFH.
// - Extended register mode: R0-R15, even WR to 30, DR0-28 step 4, 56, 60.
// - Legacy register mode addresses only banked R0-R7.
// - Legacy instructions accept only 8-bit immediates.
// - Word and dword memory operands need no alignment.
// - 16-bit displacement keeps only low 16 bits of the sum.
package doag_pkg;

    localparam int ADDR_W = 24;
    localparam logic [7:0] REGION_RESET = 8'h01;
    localparam logic [7:0] REGION_LOW = 8'h00;
    localparam logic [7:0] REGION_CODE = 8'hff;
    localparam logic [7:0] SFR_BASE = 8'h80;
    localparam logic [8:0] SFR_IMPL_LO = 9'h080;
    localparam logic [8:0] SFR_IMPL_HI = 9'h0ff;
    localparam logic [8:0] SFR_REGION_ADDR = 9'h0a1;
    localparam logic [5:0] DR_PTR_EXT = 6'h38;
    localparam logic [5:0] DR_TOP = 6'h3c;
    localparam logic [5:0] DR_LOW_MAX = 6'h1c;
    localparam logic [4:0] WR_MAX = 5'h1e;
    localparam logic [3:0] RB_MAX = 4'hf;
    localparam logic [2:0] RB_LEGACY_MAX = 3'h7;
    localparam logic [4:0] BANKED_LIMIT = 5'h08;
    localparam int BANK_SHIFT = 3;
    localparam int REGION_LSB = 16;

    typedef enum logic [3:0] {
        DOAG_MODE_REG = 4'h0, DOAG_MODE_IMM2 = 4'h1, DOAG_MODE_IMM8 = 4'h2,
        DOAG_MODE_IMM16 = 4'h3, DOAG_MODE_IMM32 = 4'h4, DOAG_MODE_DIRECT_ADDR8 = 4'h5,
        DOAG_MODE_DIRECT_ADDR16 = 4'h6, DOAG_MODE_IND_RI = 4'h7, DOAG_MODE_IND_DP = 4'h8,
        DOAG_MODE_IND_ADP = 4'h9, DOAG_MODE_IND_APC = 4'ha, DOAG_MODE_IND16 = 4'hb,
        DOAG_MODE_IND24 = 4'hc, DOAG_MODE_SIGNED_OFFSET_SHORT = 4'hd, DOAG_MODE_SIGNED_OFFSET_LONG = 4'he
    } doag_mode_e;

    typedef enum logic [2:0] {
        DOAG_SP_NONE = 3'h0, DOAG_SP_REG = 3'h1, DOAG_SP_RAM = 3'h2,
        DOAG_SP_SFR = 3'h3, DOAG_SP_CODE = 3'h4, DOAG_SP_EXT = 3'h5,
        DOAG_SP_IMM = 3'h6
    } doag_space_e;

    typedef enum logic [1:0] {
        DOAG_SZ_BYTE = 2'h0, DOAG_SZ_WORD = 2'h1, DOAG_SZ_DWORD = 2'h2
    } doag_size_e;

    // how a 16-bit immediate is widened to a dword
    typedef enum logic [1:0] {
        DOAG_EXT_ZERO = 2'h0, DOAG_EXT_ONES = 2'h1, DOAG_EXT_SIGN = 2'h2,
        DOAG_EXT_HIGH = 2'h3
    } doag_ext_e;

    typedef struct packed {
        doag_mode_e mode;
        logic legacy;
        doag_size_e size;
        logic ext_move;
        logic code_move;
        logic incdec;
        doag_ext_e ext;
        logic [5:0] reg_idx;
        logic [15:0] field;
        logic [31:0] base;
        logic [7:0] acc;
        logic [15:0] data_pointer16;
        logic [15:0] pc;
    } doag_req_s;

    typedef struct packed {
        doag_space_e space;
        logic [ADDR_W-1:0] addr;
        logic [31:0] imm;
        logic [31:0] imm_mask;
        logic fault;
    } doag_rsp_s;

    typedef struct packed {
        logic dword_we;
        logic [31:0] dword_data;
        logic sfr_we;
        logic [7:0] sfr_data;
    } doag_region_wr_s;

endpackage

/* File: rtl/doag_top.sv */
/*
 Data operand address generator: turns one decoded addressing request
 into a target space plus 24-bit effective address, or an immediate.
 Assumes the decoder presents requests on CORE_CLK with a valid strobe,
 and the core supplies the bank select, base register and pointers.
*/
`timescale 1ns/10ps
module doag_top
    import doag_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RESETN,
    // request
    input wire logic REQ_VALID,
    input wire doag_req_s REQ,
    input wire logic [1:0] BANK_SEL,
    // region writes from the core
    input wire doag_region_wr_s REGION_WR,
    // answer
    output doag_rsp_s RSP,
    output logic RSP_VALID,
    output logic [7:0] REGION_BYTE
);

    doag_rsp_s rsp_d;
    doag_rsp_s rsp_q;
    logic rsp_valid_q;
    logic [7:0] region_q;

    // register file byte address of a register operand
    function automatic logic [ADDR_W-1:0] reg_addr(input logic [5:0] idx,
                                                   input logic [1:0] bank);
        logic [ADDR_W-1:0] a;
        a = {{(ADDR_W-6){1'b0}}, idx};
        if (idx < 6'(BANKED_LIMIT)) begin
            // banked part sits in the low 32 bytes, visible as memory
            a = {{(ADDR_W-5){1'b0}}, bank, idx[2:0]};
        end
        return a;
    endfunction

    // legal register index for the operand size
    function automatic logic reg_ok(input logic [5:0] idx, input doag_size_e sz,
                                    input logic legacy);
        logic ok;
        ok = 1'b0;
        if (legacy) begin
            ok = (sz == DOAG_SZ_BYTE) && (idx <= 6'(RB_LEGACY_MAX));
        end else begin
            case (sz)
                DOAG_SZ_BYTE: ok = idx <= 6'(RB_MAX);
                DOAG_SZ_WORD: ok = !idx[0] && idx <= 6'(WR_MAX);
                DOAG_SZ_DWORD: ok = idx[1:0] == 2'b00 &&
                    (idx <= DR_LOW_MAX || idx == DR_PTR_EXT || idx == DR_TOP);
                default: ok = 1'b0;
            endcase
        end
        return ok;
    endfunction

    // external-data region, reset value 01H
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            region_q <= REGION_RESET;
        end else if (REGION_WR.dword_we) begin
            region_q <= REGION_WR.dword_data[REGION_LSB +: 8];
        end else if (REGION_WR.sfr_we) begin
            region_q <= REGION_WR.sfr_data;
        end
    end

    always_comb begin
        logic [15:0] sum16;
        logic [ADDR_W-1:0] sum24;
        logic [15:0] off;
        sum16 = '0;
        sum24 = '0;
        off = REQ.field;
        rsp_d = '0;
        rsp_d.space = DOAG_SP_NONE;
        case (REQ.mode)
            DOAG_MODE_REG: begin
                rsp_d.space = DOAG_SP_REG;
                rsp_d.addr = reg_addr(REQ.reg_idx, BANK_SEL);
                rsp_d.fault = !reg_ok(REQ.reg_idx, REQ.size, REQ.legacy);
            end
            DOAG_MODE_IMM2: begin
                rsp_d.space = DOAG_SP_IMM;
                case (REQ.field[1:0])
                    2'h0: rsp_d.imm = 32'h0000_0001;
                    2'h1: rsp_d.imm = 32'h0000_0002;
                    2'h2: rsp_d.imm = 32'h0000_0004;
                    default: rsp_d.fault = 1'b1;
                endcase
                rsp_d.imm_mask = 32'hffff_ffff;
                if (!REQ.incdec || REQ.legacy) begin
                    rsp_d.fault = 1'b1;
                end
            end
            DOAG_MODE_IMM8: begin
                rsp_d.space = DOAG_SP_IMM;
                rsp_d.imm = {24'h00_0000, REQ.field[7:0]};
                rsp_d.imm_mask = 32'h0000_00ff;
                rsp_d.fault = REQ.size != DOAG_SZ_BYTE;
            end
            DOAG_MODE_IMM16: begin
                rsp_d.space = DOAG_SP_IMM;
                rsp_d.imm = {16'h0000, REQ.field};
                rsp_d.imm_mask = 32'h0000_ffff;
                rsp_d.fault = REQ.legacy || REQ.size != DOAG_SZ_WORD;
            end
            DOAG_MODE_IMM32: begin
                rsp_d.space = DOAG_SP_IMM;
                rsp_d.imm_mask = 32'hffff_ffff;
                case (REQ.ext)
                    DOAG_EXT_ZERO: rsp_d.imm = {16'h0000, REQ.field};
                    DOAG_EXT_ONES: rsp_d.imm = {16'hffff, REQ.field};
                    DOAG_EXT_SIGN: rsp_d.imm = {{16{REQ.field[15]}}, REQ.field};
                    DOAG_EXT_HIGH: begin
                        // low word kept: the write mask covers the upper half only
                        rsp_d.imm = {REQ.field, 16'h0000};
                        rsp_d.imm_mask = 32'hffff_0000;
                    end
                    default: rsp_d.fault = 1'b1;
                endcase
                if (REQ.legacy || REQ.size != DOAG_SZ_DWORD) begin
                    rsp_d.fault = 1'b1;
                end
            end
            DOAG_MODE_DIRECT_ADDR8: begin
                rsp_d.addr = {REGION_LOW, 8'h00, REQ.field[7:0]};
                if (REQ.field[7:0] < SFR_BASE) begin
                    rsp_d.space = DOAG_SP_RAM;
                    rsp_d.fault = REQ.legacy ? (REQ.size != DOAG_SZ_BYTE)
                                             : (REQ.size == DOAG_SZ_DWORD);
                end else begin
                    rsp_d.space = DOAG_SP_SFR;
                    rsp_d.fault = REQ.size != DOAG_SZ_BYTE ||
                        ({1'b0, REQ.field[7:0]} > SFR_IMPL_HI) ||
                        ({1'b0, REQ.field[7:0]} < SFR_IMPL_LO);
                end
            end
            DOAG_MODE_DIRECT_ADDR16: begin
                rsp_d.space = DOAG_SP_RAM;
                rsp_d.addr = {REGION_LOW, REQ.field};
                rsp_d.fault = REQ.legacy || REQ.size == DOAG_SZ_DWORD;
            end
            DOAG_MODE_IND_RI: begin
                if (REQ.ext_move) begin
                    rsp_d.space = DOAG_SP_EXT;
                    rsp_d.addr = {region_q, 8'h00, REQ.base[7:0]};
                end else begin
                    rsp_d.space = DOAG_SP_RAM;
                    rsp_d.addr = {REGION_LOW, 8'h00, REQ.base[7:0]};
                end
                rsp_d.fault = REQ.reg_idx > 6'h01;
            end
            DOAG_MODE_IND_DP, DOAG_MODE_IND_ADP: begin
                sum16 = REQ.data_pointer16;
                if (REQ.mode == DOAG_MODE_IND_ADP) begin
                    sum16 = 16'(REQ.data_pointer16 + {8'h00, REQ.acc});
                end
                if (REQ.code_move && REQ.mode == DOAG_MODE_IND_ADP) begin
                    rsp_d.space = DOAG_SP_CODE;
                    rsp_d.addr = {REGION_CODE, sum16};
                end else begin
                    rsp_d.space = DOAG_SP_EXT;
                    rsp_d.addr = {region_q, sum16};
                    rsp_d.fault = !REQ.ext_move;
                end
            end
            DOAG_MODE_IND_APC: begin
                rsp_d.space = DOAG_SP_CODE;
                rsp_d.addr = {REGION_CODE, 16'(REQ.pc + {8'h00, REQ.acc})};
                rsp_d.fault = !REQ.code_move;
            end
            DOAG_MODE_IND16: begin
                rsp_d.space = DOAG_SP_RAM;
                rsp_d.addr = {REGION_LOW, REQ.base[15:0]};
            end
            DOAG_MODE_IND24: begin
                rsp_d.space = DOAG_SP_RAM;
                rsp_d.addr = REQ.base[ADDR_W-1:0];
                rsp_d.fault = REQ.base[31:ADDR_W] != 8'h00;
            end
            DOAG_MODE_SIGNED_OFFSET_SHORT: begin
                // carry or borrow out of bit 15 is dropped on purpose
                sum16 = 16'(REQ.base[15:0] + off);
                rsp_d.space = DOAG_SP_RAM;
                rsp_d.addr = {REGION_LOW, sum16};
            end
            DOAG_MODE_SIGNED_OFFSET_LONG: begin
                sum24 = ADDR_W'(REQ.base[ADDR_W-1:0] + {{8{off[15]}}, off});
                rsp_d.space = DOAG_SP_RAM;
                rsp_d.addr = sum24;
                rsp_d.fault = REQ.base[31:ADDR_W] != 8'h00;
            end
            default: begin
                rsp_d.fault = 1'b1;
            end
        endcase
        if (rsp_d.space == DOAG_SP_RAM && rsp_d.addr < ADDR_W'(32)) begin
            // low 32 bytes of memory alias the register banks
            rsp_d.space = DOAG_SP_REG;
        end
    end

    // one registered answer per valid request
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rsp_q <= '0;
            rsp_valid_q <= 1'b0;
        end else begin
            rsp_valid_q <= REQ_VALID;
            if (REQ_VALID) begin
                rsp_q <= rsp_d;
            end
        end
    end

    assign RSP = rsp_q;
    assign RSP_VALID = rsp_valid_q;
    assign REGION_BYTE = region_q;

endmodule

/* File: tb/data_operand_address_generator_test.sv */
/*
 Self-checking bench for the data operand address generator.
 Assumes fixed one-cycle answer latency and the core model beside it.
*/
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
    $display("mismatch %s expected %h seen %h", nm, ex, got); fails++; end end
module data_operand_address_generator_test
    import doag_pkg::*;
;
    logic core_clk = 1'b0;
    logic resetn = 1'b1;
    logic req_valid = 1'b0;
    doag_req_s req = '0;
    logic [1:0] bank_sel;
    doag_region_wr_s region_wr;
    doag_rsp_s rsp;
    logic rsp_valid;
    logic [7:0] region_byte;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;

    doag_top DUT (.CORE_CLK(core_clk), .RESETN(resetn), .REQ_VALID(req_valid), .REQ(req),
        .BANK_SEL(bank_sel), .REGION_WR(region_wr), .RSP(rsp), .RSP_VALID(rsp_valid),
        .REGION_BYTE(region_byte));
    doag_core_model core (.clk(core_clk), .region_wr(region_wr), .bank_sel(bank_sel));

    initial begin
        forever #20 core_clk = ~core_clk;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // the whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles >= 5000) begin
            fails++;
            conclude();
        end
    end

    function automatic doag_req_s mk(doag_mode_e m, logic leg, logic [15:0] f, logic [31:0] b);
        doag_req_s r;
        r = '0;
        r.mode = m;
        r.legacy = leg;
        r.field = f;
        r.base = b;
        return r;
    endfunction

    // answer is looked at in its single valid cycle
    task automatic issue(input doag_req_s r);
        @(negedge core_clk);
        req = r;
        req_valid = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
        `CHK("valid", 1'b1, rsp_valid)
    endtask

    task automatic expect_ok(input doag_space_e sp, input logic [23:0] a);
        `CHK("space", sp, rsp.space)
        `CHK("addr", a, rsp.addr)
        `CHK("fault", 1'b0, rsp.fault)
    endtask

    task automatic t_signed_offset_short();
        issue(mk(DOAG_MODE_SIGNED_OFFSET_SHORT, 1'b0, 16'h2005, 32'h0000f000));
        expect_ok(DOAG_SP_RAM, 24'h001005);
        issue(mk(DOAG_MODE_SIGNED_OFFSET_SHORT, 1'b0, 16'hf000, 32'h00002005));
        expect_ok(DOAG_SP_RAM, 24'h001005);
    endtask

    task automatic t_bank();
        doag_req_s r;
        r = mk(DOAG_MODE_REG, 1'b1, 16'h0000, 32'h0);
        r.reg_idx = 6'h03;
        core.set_bank(2'h2);
        issue(r);
        expect_ok(DOAG_SP_REG, 24'h000013);
        core.set_bank(2'h0);
        issue(r);
        expect_ok(DOAG_SP_REG, 24'h000003);
        r.reg_idx = 6'h08;
        issue(r);
        `CHK("legacy reg fault", 1'b1, rsp.fault)
    endtask

    task automatic t_direct();
        doag_req_s r;
        issue(mk(DOAG_MODE_DIRECT_ADDR8, 1'b1, 16'h0040, 32'h0));
        expect_ok(DOAG_SP_RAM, 24'h000040);
        issue(mk(DOAG_MODE_DIRECT_ADDR8, 1'b1, 16'h0090, 32'h0));
        `CHK("sfr space", DOAG_SP_SFR, rsp.space)
        r = mk(DOAG_MODE_DIRECT_ADDR8, 1'b1, 16'h0040, 32'h0);
        r.size = DOAG_SZ_WORD;
        issue(r);
        `CHK("legacy word fault", 1'b1, rsp.fault)
        r.legacy = 1'b0;
        issue(r);
        expect_ok(DOAG_SP_RAM, 24'h000040);
        r = mk(DOAG_MODE_DIRECT_ADDR16, 1'b0, 16'habcd, 32'h0);
        r.size = DOAG_SZ_WORD;
        issue(r);
        expect_ok(DOAG_SP_RAM, 24'h00abcd);
    endtask

    task automatic t_imm();
        doag_req_s r;
        for (int c = 0; c < 4; c++) begin
            r = mk(DOAG_MODE_IMM2, 1'b0, 16'(c), 32'h0);
            r.incdec = 1'b1;
            issue(r);
            `CHK("step fault", (c == 3), rsp.fault)
            if (c < 3) `CHK("step", 32'(1 << c), rsp.imm)
        end
        issue(mk(DOAG_MODE_IMM16, 1'b1, 16'h1234, 32'h0));
        `CHK("legacy imm16 fault", 1'b1, rsp.fault)
        r = mk(DOAG_MODE_IMM32, 1'b0, 16'h1234, 32'h0);
        r.size = DOAG_SZ_DWORD;
        r.ext = DOAG_EXT_ONES;
        issue(r);
        `CHK("imm ones", 32'hffff1234, rsp.imm)
    endtask

    task automatic t_region();
        doag_req_s r;
        `CHK("region reset", 8'h01, region_byte)
        core.wr_region(1'b0, 32'h00000005);
        `CHK("region sfr", 8'h05, region_byte)
        r = mk(DOAG_MODE_IND_DP, 1'b1, 16'h0000, 32'h0);
        r.ext_move = 1'b1;
        r.data_pointer16 = 16'h1234;
        issue(r);
        expect_ok(DOAG_SP_EXT, 24'h051234);
        core.wr_region(1'b1, 32'h00220000);
        `CHK("region dword", 8'h22, region_byte)
        // mid-run reset must bring the region back to its reset value
        @(negedge core_clk);
        resetn = 1'b0;
        @(negedge core_clk);
        `CHK("region after reset", 8'h01, region_byte)
        `CHK("valid in reset", 1'b0, rsp_valid)
        resetn = 1'b1;
    endtask

    task automatic t_long();
        doag_req_s r;
        issue(mk(DOAG_MODE_IND24, 1'b0, 16'h0000, 32'h00123456));
        expect_ok(DOAG_SP_RAM, 24'h123456);
        issue(mk(DOAG_MODE_IND24, 1'b0, 16'h0000, 32'h01123456));
        `CHK("upper byte fault", 1'b1, rsp.fault)
        r = mk(DOAG_MODE_IND_APC, 1'b1, 16'h0000, 32'h0);
        r.code_move = 1'b1;
        r.acc = 8'h10;
        r.pc = 16'h2000;
        issue(r);
        expect_ok(DOAG_SP_CODE, 24'hff2010);
    endtask

    // modes, widenings and cases not reached by the scenarios above
    task automatic t_more();
        doag_req_s r;
        issue(mk(DOAG_MODE_IMM8, 1'b0, 16'h12ab, 32'h0));
        `CHK("imm8", 32'h000000ab, rsp.imm)
        `CHK("imm8 mask", 32'h000000ff, rsp.imm_mask)
        `CHK("imm8 fault", 1'b0, rsp.fault)
        issue(mk(DOAG_MODE_IMM2, 1'b0, 16'h0000, 32'h0));
        `CHK("step outside incdec", 1'b1, rsp.fault)
        r = mk(DOAG_MODE_IMM32, 1'b0, 16'h8001, 32'h0);
        r.size = DOAG_SZ_DWORD;
        r.ext = DOAG_EXT_SIGN;
        issue(r);
        `CHK("imm sign", 32'hffff8001, rsp.imm)
        r.ext = DOAG_EXT_HIGH;
        issue(r);
        `CHK("imm high", 32'h80010000, rsp.imm)
        `CHK("imm high mask", 32'hffff0000, rsp.imm_mask)
        r = mk(DOAG_MODE_IND_RI, 1'b1, 16'h0000, 32'h000000c3);
        r.reg_idx = 6'h01;
        issue(r);
        expect_ok(DOAG_SP_RAM, 24'h0000c3);
        r.ext_move = 1'b1;
        issue(r);
        expect_ok(DOAG_SP_EXT, 24'h0100c3);
        issue(mk(DOAG_MODE_SIGNED_OFFSET_LONG, 1'b0, 16'hffff, 32'h00123456));
        expect_ok(DOAG_SP_RAM, 24'h123455);
        issue(mk(DOAG_MODE_SIGNED_OFFSET_LONG, 1'b0, 16'h0001, 32'h80123456));
        `CHK("signed_offset_long upper fault", 1'b1, rsp.fault)
        issue(mk(DOAG_MODE_IND16, 1'b0, 16'h0000, 32'h00ff1234));
        expect_ok(DOAG_SP_RAM, 24'h001234);
        r = mk(DOAG_MODE_IND_ADP, 1'b1, 16'h0000, 32'h0);
        r.code_move = 1'b1;
        r.acc = 8'h10;
        r.data_pointer16 = 16'hfff8;
        issue(r);
        expect_ok(DOAG_SP_CODE, 24'hff0008);
        r = mk(DOAG_MODE_REG, 1'b0, 16'h0000, 32'h0);
        r.size = DOAG_SZ_DWORD;
        r.reg_idx = 6'h3c;
        issue(r);
        expect_ok(DOAG_SP_REG, 24'h00003c);
        r.reg_idx = 6'h20;
        issue(r);
        `CHK("dword index fault", 1'b1, rsp.fault)
        r.size = DOAG_SZ_WORD;
        r.reg_idx = 6'h1e;
        issue(r);
        expect_ok(DOAG_SP_REG, 24'h00001e);
    endtask

    initial begin
        // a real falling edge, so the asynchronous reset acts before the first clock
        #1 resetn = 1'b0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        resetn = 1'b1;
        `CHK("idle valid", 1'b0, rsp_valid)
        t_region();
        t_signed_offset_short();
        t_bank();
        t_direct();
        t_imm();
        t_long();
        t_more();
        conclude();
    end
endmodule

/* File: tb/doag_checker.sv */
/*
 Concurrent checks on the address generator's top-level ports.
 Assumes one core clock domain with an active-low asynchronous reset.
*/
`timescale 1ns/10ps
module doag_checker
    import doag_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RESETN,
    // request side
    input wire logic REQ_VALID,
    input wire doag_req_s REQ,
    input wire logic [1:0] BANK_SEL,
    input wire doag_region_wr_s REGION_WR,
    // answer side
    input wire doag_rsp_s RSP,
    input wire logic RSP_VALID,
    input wire logic [7:0] REGION_BYTE
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    logic [15:0] dis_sum_q;

    // carry out of bit 15 is dropped on purpose
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            dis_sum_q <= 16'h0000;
        end else begin
            dis_sum_q <= REQ.base[15:0] + REQ.field;
        end
    end

    rsp_pulse_a: assert property (REQ_VALID |=> RSP_VALID)
        else $error("answer strobe missing after request");
    rsp_quiet_a: assert property (!REQ_VALID |=> !RSP_VALID)
        else $error("answer strobe without request");
    rsp_hold_a: assert property (!REQ_VALID |=> $stable(RSP))
        else $error("answer changed without request");
    region_reset_a: assert property (disable iff (1'b0)
        !RESETN |-> REGION_BYTE == REGION_RESET)
        else $error("region byte wrong in reset");
    region_dword_a: assert property (REGION_WR.dword_we |=>
        REGION_BYTE == $past(REGION_WR.dword_data[23:16]))
        else $error("dword write did not set region");
    region_sfr_a: assert property (REGION_WR.sfr_we && !REGION_WR.dword_we |=>
        REGION_BYTE == $past(REGION_WR.sfr_data))
        else $error("byte write did not set region");
    region_hold_a: assert property (!REGION_WR.sfr_we && !REGION_WR.dword_we |=>
        $stable(REGION_BYTE))
        else $error("region byte changed without write");
    signed_offset_short_wrap_a: assert property (REQ_VALID && REQ.mode == DOAG_MODE_SIGNED_OFFSET_SHORT |=>
        RSP.fault || RSP.addr == {8'h00, dis_sum_q})
        else $error("short displacement address wrong");
    ind24_upper_a: assert property (REQ_VALID && REQ.mode == DOAG_MODE_IND24 &&
        REQ.base[31:24] != 8'h00 |=> RSP.fault)
        else $error("nonzero upper base byte accepted");
    code_region_a: assert property (REQ_VALID && REQ.mode == DOAG_MODE_IND_APC &&
        REQ.code_move |=> RSP.fault || RSP.addr[23:16] == REGION_CODE)
        else $error("code move outside code region");

    cover property (REQ_VALID && REQ.mode == DOAG_MODE_SIGNED_OFFSET_SHORT);
    cover property (REGION_WR.sfr_we);
    cover property (RSP_VALID && RSP.fault);
    cover property (REQ_VALID && REQ.mode == DOAG_MODE_SIGNED_OFFSET_LONG);
endmodule

bind doag_top doag_checker u_chk (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .REQ_VALID(REQ_VALID),
    .REQ(REQ), .BANK_SEL(BANK_SEL), .REGION_WR(REGION_WR), .RSP(RSP),
    .RSP_VALID(RSP_VALID), .REGION_BYTE(REGION_BYTE));

/* File: tb/doag_core_model.sv */
/*
 Behavioural execution core: bank select and external-region writes.
 Assumes the bench calls its tasks; all changes land at the falling edge.
*/
`timescale 1ns/10ps
module doag_core_model
    import doag_pkg::*;
(
    // clock
    input wire logic clk,
    // core outputs
    output doag_region_wr_s region_wr,
    output logic [1:0] bank_sel
);
    initial begin
        region_wr = '0;
        bank_sel = 2'h0;
    end

    task automatic set_bank(input logic [1:0] b);
        @(negedge clk);
        bank_sel = b;
    endtask

    // one-cycle strobe; released data is inverted so stale values are not reused
    task automatic wr_region(input logic dw, input logic [31:0] d);
        @(negedge clk);
        region_wr.dword_we = dw;
        region_wr.sfr_we = !dw;
        region_wr.dword_data = d;
        region_wr.sfr_data = d[7:0];
        @(negedge clk);
        region_wr = '{dword_we: 1'b0, dword_data: ~d, sfr_we: 1'b0, sfr_data: ~d[7:0]};
    endtask
endmodule
